// *** gma_ahb_master.sv ***
// AHB-Lite master model standing in for the processor core.
// Assumes one slave; waits on hreadyout although it is always high.
`timescale 1ns/100ps
module gma_ahb_master (
    // Clock
    input wire logic i_sys_clk,
    // Bus requests
    output logic o_hsel,
    output logic [11:0] o_haddr,
    output logic [1:0] o_htrans,
    output logic o_hwrite,
    output logic [2:0] o_hsize,
    output logic [31:0] o_hwdata,
    output logic o_hready,
    // Bus answers
    input wire logic i_hreadyout,
    input wire logic [31:0] i_hrdata
);
    initial begin
        o_hsel = 1'b0;
        o_haddr = 12'h000;
        o_htrans = 2'h0;
        o_hwrite = 1'b0;
        o_hsize = 3'h2;
        o_hwdata = 32'h0000_0000;
        o_hready = 1'b1;
    end

    // One word transfer: address phase, then data phase
    task automatic xfer(input logic wr, input logic [11:0] a,
        input logic [15:0] wd, output logic [31:0] rd);
        @(posedge i_sys_clk);
        o_hsel <= 1'b1;
        o_htrans <= 2'h2;
        o_hwrite <= wr;
        o_haddr <= a;
        @(posedge i_sys_clk);
        o_hsel <= 1'b0;
        o_htrans <= 2'h0;
        o_hwdata <= wr ? {16'h0000, wd} : ~o_hwdata;
        @(posedge i_sys_clk);
        for (int n = 0; n < 16 && i_hreadyout !== 1'b1; n++) begin
            @(posedge i_sys_clk);
        end
        rd = i_hrdata;
        // Stale data must not look valid after the data phase
        o_hwdata <= ~o_hwdata;
    endtask
endmodule

// *** gma_pkg.sv ***
// Constants for the masked-access GPIO register bank.
// Assumes an AHB-Lite master on the system bus clock.
package gma_pkg;

    // ********************
    // Widths
    // ********************
    localparam int unsigned GMA_PORT_W = 16;
    localparam int unsigned GMA_HALF_W = 8;
    localparam int unsigned GMA_ADDR_W = 12;
    localparam int unsigned GMA_SYNC_STAGES = 2;

    // ********************
    // Register offsets
    // ********************
    localparam logic [11:0] GMA_OFS_PIN_VALUE = 12'h000;
    localparam logic [11:0] GMA_OFS_OUTPUT_LATCH = 12'h004;
    localparam logic [11:0] GMA_OFS_DIRECTION_SET = 12'h010;
    localparam logic [11:0] GMA_OFS_DIRECTION_CLEAR = 12'h014;
    localparam logic [11:0] GMA_OFS_PIN_FUNCTION_SET = 12'h018;
    localparam logic [11:0] GMA_OFS_PIN_FUNCTION_CLEAR = 12'h01C;
    localparam logic [11:0] GMA_OFS_IRQ_ENABLE_SET = 12'h020;

    // ********************
    // Masked windows: address bits 11:10 pick the window
    // ********************
    localparam logic [1:0] GMA_WIN_LOW = 2'h1;
    localparam logic [1:0] GMA_WIN_HIGH = 2'h2;
    localparam int unsigned GMA_WIN_MSB = 11;
    localparam int unsigned GMA_WIN_LSB = 10;
    localparam int unsigned GMA_MASK_MSB = 9;
    localparam int unsigned GMA_MASK_LSB = 2;

    // ********************
    // Reset values
    // ********************
    localparam logic [15:0] GMA_RST_ZERO = 16'h0000;
    localparam logic [15:0] GMA_FUNC_AVAIL_DEF = 16'hFFFF;
    localparam logic [15:0] GMA_FUNC_RESET_DEF = 16'h0000;

    // ********************
    // AHB encodings
    // ********************
    localparam logic [1:0] GMA_HTRANS_NONSEQ = 2'h2;
    localparam int unsigned GMA_HTRANS_ACTIVE_BIT = 1;
    localparam logic GMA_HRESP_OKAY = 1'b0;

endpackage

// *** gma_regs.sv ***
// Register bank and masked access of a 16-bit GPIO port, AHB-Lite slave.
// Assumes a single AHB-Lite master; zero wait states, always OKAY.
`timescale 1ns/100ps
module gma_regs
    import gma_pkg::*;
#(
    parameter logic [15:0] FUNC_AVAIL = GMA_FUNC_AVAIL_DEF,
    parameter logic [15:0] FUNC_RESET = GMA_FUNC_RESET_DEF
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    // AHB-Lite slave
    input wire logic i_hsel,
    input wire logic [gma_pkg::GMA_ADDR_W-1:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [31:0] o_hrdata,
    // Port pins
    input wire logic [gma_pkg::GMA_PORT_W-1:0] i_port_in,
    output logic [gma_pkg::GMA_PORT_W-1:0] o_port_out,
    output logic [gma_pkg::GMA_PORT_W-1:0] o_port_oe,
    output logic [gma_pkg::GMA_PORT_W-1:0] o_pin_function_select,
    output logic [gma_pkg::GMA_PORT_W-1:0] o_irq_enable
);
    import gma_pkg::*;

    // ********************
    // Input synchroniser
    // ********************
    logic [GMA_PORT_W-1:0] pin_sync;

    gma_sync #(
        .WIDTH(GMA_PORT_W)
    ) u_sync (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .i_async(i_port_in),
        .o_sync(pin_sync)
    );

    // ********************
    // Address phase capture
    // ********************
    logic wr_pend_q;
    logic wr_pend_d;
    logic [GMA_ADDR_W-1:0] wr_addr_q;
    logic [GMA_ADDR_W-1:0] wr_addr_d;
    logic rd_take;

    // Reads answer from the address phase; writes wait for the data phase
    assign rd_take = i_hsel & i_hready & i_htrans[GMA_HTRANS_ACTIVE_BIT]
                     & ~i_hwrite;

    always_comb begin
        wr_pend_d = i_hsel & i_hready & i_htrans[GMA_HTRANS_ACTIVE_BIT]
                    & i_hwrite;
        wr_addr_d = wr_pend_d ? i_haddr : wr_addr_q;
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
        end else begin
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
        end
    end

    // ********************
    // Write decode
    // ********************
    logic [GMA_PORT_W-1:0] wdata;
    logic [GMA_HALF_W-1:0] wr_mask;
    logic [1:0] wr_win;
    logic [GMA_PORT_W-1:0] out_q;
    logic [GMA_PORT_W-1:0] out_d;
    logic [GMA_PORT_W-1:0] oe_q;
    logic [GMA_PORT_W-1:0] oe_d;
    logic [GMA_PORT_W-1:0] func_q;
    logic [GMA_PORT_W-1:0] func_d;
    logic [GMA_PORT_W-1:0] irqen_q;
    logic [GMA_PORT_W-1:0] irqen_d;
    logic [GMA_PORT_W-1:0] bitmask;

    assign wdata = i_hwdata[GMA_PORT_W-1:0];
    assign wr_mask = wr_addr_q[GMA_MASK_MSB:GMA_MASK_LSB];
    assign wr_win = wr_addr_q[GMA_WIN_MSB:GMA_WIN_LSB];

    always_comb begin
        out_d = out_q;
        oe_d = oe_q;
        func_d = func_q;
        irqen_d = irqen_q;
        bitmask = '0;
        if (wr_pend_q) begin
            if (wr_win == GMA_WIN_LOW) begin
                bitmask = {{GMA_HALF_W{1'b0}}, wr_mask};
            end else if (wr_win == GMA_WIN_HIGH) begin
                bitmask = {wr_mask, {GMA_HALF_W{1'b0}}};
            end
            // Masked windows; unmasked half is never touched
            out_d = (out_q & ~bitmask) | (wdata & bitmask);
            if (wr_win == '0) begin
                unique case (wr_addr_q)
                    GMA_OFS_PIN_VALUE,
                    GMA_OFS_OUTPUT_LATCH: begin
                        out_d = wdata;
                    end
                    GMA_OFS_DIRECTION_SET: begin
                        oe_d = oe_q | wdata;
                    end
                    GMA_OFS_DIRECTION_CLEAR: begin
                        oe_d = oe_q & ~wdata;
                    end
                    GMA_OFS_PIN_FUNCTION_SET: begin
                        func_d = func_q | (wdata & FUNC_AVAIL);
                    end
                    GMA_OFS_PIN_FUNCTION_CLEAR: begin
                        func_d = func_q & ~wdata;
                    end
                    GMA_OFS_IRQ_ENABLE_SET: begin
                        irqen_d = irqen_q | wdata;
                    end
                    default: begin
                        out_d = out_q;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            out_q <= GMA_RST_ZERO;
            oe_q <= GMA_RST_ZERO;
            func_q <= FUNC_RESET;
            irqen_q <= GMA_RST_ZERO;
        end else begin
            out_q <= out_d;
            oe_q <= oe_d;
            func_q <= func_d;
            irqen_q <= irqen_d;
        end
    end

    // ********************
    // Read path
    // ********************
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [GMA_HALF_W-1:0] rd_mask;
    logic [1:0] rd_win;
    logic [GMA_PORT_W-1:0] rd_val;

    assign rd_mask = i_haddr[GMA_MASK_MSB:GMA_MASK_LSB];
    assign rd_win = i_haddr[GMA_WIN_MSB:GMA_WIN_LSB];

    always_comb begin
        rd_val = '0;
        if (rd_win == GMA_WIN_LOW) begin
            rd_val = pin_sync & {{GMA_HALF_W{1'b0}}, rd_mask};
        end else if (rd_win == GMA_WIN_HIGH) begin
            rd_val = pin_sync & {rd_mask, {GMA_HALF_W{1'b0}}};
        end else if (rd_win == '0) begin
            unique case (i_haddr)
                GMA_OFS_PIN_VALUE: rd_val = pin_sync;
                GMA_OFS_OUTPUT_LATCH: rd_val = out_q;
                GMA_OFS_DIRECTION_SET,
                GMA_OFS_DIRECTION_CLEAR: rd_val = oe_q;
                GMA_OFS_PIN_FUNCTION_SET,
                GMA_OFS_PIN_FUNCTION_CLEAR: rd_val = func_q;
                GMA_OFS_IRQ_ENABLE_SET: rd_val = irqen_q;
                default: rd_val = '0;
            endcase
        end
        rdata_d = rd_take ? {16'h0000, rd_val} : '0;
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // Zero wait states, so hreadyout is constant
    assign o_hreadyout = 1'b1;
    assign o_hresp = GMA_HRESP_OKAY;
    assign o_hrdata = rdata_q;
    assign o_port_out = out_q;
    assign o_port_oe = oe_q;
    assign o_pin_function_select = func_q;
    assign o_irq_enable = irqen_q;

    // ********************
    // Assertions
    // ********************
    // Writes land at the edge that ends the data phase, so checks look
    // one cycle on and compare against the state sampled before it
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);

    a_low_masked_write: assert property (
        wr_pend_q && wr_win == GMA_WIN_LOW
        |=> o_port_out[15:8] == $past(out_q[15:8]))
        else $error("Low window write touched upper byte");
    a_high_masked_write: assert property (
        wr_pend_q && wr_win == GMA_WIN_HIGH
        |=> o_port_out[7:0] == $past(out_q[7:0]))
        else $error("High window write touched lower byte");
    a_mask_merge_bits: assert property (
        wr_pend_q && wr_win == GMA_WIN_LOW
        |=> o_port_out[7:0] == (($past(out_q[7:0]) & ~$past(wr_mask))
            | ($past(wdata[7:0]) & $past(wr_mask))))
        else $error("Masked write merge wrong");
    a_high_merge_bits: assert property (
        wr_pend_q && wr_win == GMA_WIN_HIGH
        |=> o_port_out[15:8] == (($past(out_q[15:8]) & ~$past(wr_mask))
            | ($past(wdata[15:8]) & $past(wr_mask))))
        else $error("High masked write merge wrong");
    // Reset clears both flops, so only check once they hold real samples
    a_pin_read_lag: assert property (
        rd_take && i_haddr == GMA_OFS_PIN_VALUE
        && $past(i_rst_b) && $past(i_rst_b, 2)
        |=> o_hrdata[15:0] == $past(i_port_in, 3))
        else $error("Pin read not two stages behind");
    a_latch_write: assert property (
        wr_pend_q && wr_addr_q == GMA_OFS_OUTPUT_LATCH
        |=> o_port_out == $past(wdata))
        else $error("Output latch not loaded");
    a_data_write: assert property (
        wr_pend_q && wr_addr_q == GMA_OFS_PIN_VALUE
        |=> o_port_out == $past(wdata))
        else $error("Data write did not load latch");
    a_dir_set: assert property (
        wr_pend_q && wr_addr_q == GMA_OFS_DIRECTION_SET
        |=> (o_port_oe & $past(wdata)) == $past(wdata)
            && ($past(oe_q) & ~o_port_oe) == '0)
        else $error("Direction set wrong");
    a_dir_clear: assert property (
        wr_pend_q && wr_addr_q == GMA_OFS_DIRECTION_CLEAR
        |=> (o_port_oe & $past(wdata)) == '0
            && (o_port_oe & ~$past(oe_q)) == '0)
        else $error("Direction clear wrong");
    a_func_clear: assert property (
        wr_pend_q && wr_addr_q == GMA_OFS_PIN_FUNCTION_CLEAR
        |=> (o_pin_function_select & $past(wdata)) == '0)
        else $error("Function clear wrong");
    a_func_set: assert property (
        wr_pend_q && wr_addr_q == GMA_OFS_PIN_FUNCTION_SET
        |=> (o_pin_function_select & $past(wdata) & FUNC_AVAIL)
            == ($past(wdata) & FUNC_AVAIL))
        else $error("Function set wrong");
    a_irq_set_only: assert property (
        $past(i_rst_b)
        |-> (o_irq_enable & $past(o_irq_enable)) == $past(o_irq_enable))
        else $error("Interrupt enable dropped");
    a_masked_read: assert property (
        rd_take && rd_win == GMA_WIN_HIGH
        |=> o_hrdata[7:0] == 8'h00 && o_hrdata[31:16] == 16'h0000
            && o_hrdata[15:8] == ($past(pin_sync[15:8]) & $past(rd_mask)))
        else $error("High window read wrong");
    a_low_masked_read: assert property (
        rd_take && rd_win == GMA_WIN_LOW
        |=> o_hrdata[31:8] == 24'h00_0000
            && o_hrdata[7:0] == ($past(pin_sync[7:0]) & $past(rd_mask)))
        else $error("Low window read wrong");
    // Only a write data phase may move the control state
    a_state_hold: assert property (
        !wr_pend_q
        |=> $stable(o_port_out) && $stable(o_port_oe)
            && $stable(o_pin_function_select) && $stable(o_irq_enable))
        else $error("Control state moved without a write");

    // ********************
    // Covers
    // ********************
    c_low_write: cover property (wr_pend_q && wr_win == GMA_WIN_LOW);
    c_high_read: cover property (rd_take && rd_win == GMA_WIN_HIGH);
    c_dir_set: cover property (wr_pend_q
        && wr_addr_q == GMA_OFS_DIRECTION_SET);
    c_back_to_back: cover property (wr_pend_q && rd_take);
endmodule

// *** gma_sync.sv ***
// Two-stage synchroniser for the port input pins.
// Assumes pins may change at any time relative to the clock.
`timescale 1ns/100ps
module gma_sync #(
    parameter int unsigned WIDTH = 16
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    // Data
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    always_comb begin
        meta_d = i_async;
        sync_d = meta_q;
    end

    // First stage is read only by the second stage
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign o_sync = sync_q;
endmodule

// *** gpio_masked_access_regs_test.sv ***
// Self-checking bench for the masked-access GPIO register bank.
// Assumes the bus master model drives every bus input.
`timescale 1ns/100ps
module gpio_masked_access_regs_test;
    import gma_pkg::*;
    logic i_sys_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic [15:0] port_in = 16'h0000;
    logic hsel, hwrite, hready, hreadyout, hresp;
    logic [11:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata;
    logic [15:0] port_out, port_oe, func_sel, irq_en, exp_out;
    logic [11:0] ofs [6] = '{12'h004, 12'h010, 12'h014, 12'h018,
        12'h01C, 12'h020};
    logic [7:0] mk [4] = '{8'h00, 8'h01, 8'h80, 8'hFF};
    int n_errors = 0;
    int checks_done = 0;

    always #12.5 i_sys_clk = ~i_sys_clk;

    gma_ahb_master u_mst (.i_sys_clk(i_sys_clk), .o_hsel(hsel),
        .o_haddr(haddr), .o_htrans(htrans), .o_hwrite(hwrite),
        .o_hsize(hsize), .o_hwdata(hwdata), .o_hready(hready),
        .i_hreadyout(hreadyout), .i_hrdata(hrdata));

    gma_regs DUT (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
        .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
        .i_hready(hready), .o_hreadyout(hreadyout), .o_hresp(hresp),
        .o_hrdata(hrdata), .i_port_in(port_in), .o_port_out(port_out),
        .o_port_oe(port_oe), .o_pin_function_select(func_sel),
        .o_irq_enable(irq_en));

    task automatic check(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        logic [31:0] v;
        u_mst.xfer(1'b1, a, d, v);
    endtask

    task automatic rd(input logic [11:0] a, input logic [15:0] exp);
        logic [31:0] v;
        u_mst.xfer(1'b0, a, 16'h0000, v);
        check($sformatf("read %h", a), {16'h0000, exp}, v);
    endtask

    // Masked write; the ignored half carries the inverse as bait
    task automatic mw(input logic hi, input logic [7:0] m,
        input logic [7:0] d);
        wr({hi, ~hi, m, 2'h0}, hi ? {d, ~d} : {~d, d});
        if (hi) begin
            exp_out[15:8] = (exp_out[15:8] & ~m) | (d & m);
        end else begin
            exp_out[7:0] = (exp_out[7:0] & ~m) | (d & m);
        end
        @(negedge i_sys_clk);
        check("port out", {16'h0000, exp_out}, {16'h0000, port_out});
    endtask

    task automatic results;
        if (n_errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ********************
    // Tests
    // ********************
    initial begin
        exp_out = 16'h0000;
        repeat (2) @(posedge i_sys_clk);
        i_rst_b <= 1'b1;
        foreach (ofs[i]) rd(ofs[i], 16'h0000);
        wr(GMA_OFS_OUTPUT_LATCH, 16'hA5A5);
        exp_out = 16'hA5A5;
        rd(GMA_OFS_OUTPUT_LATCH, 16'hA5A5);
        mw(1'b0, 8'hC3, 8'h03);
        mw(1'b1, 8'h0F, 8'h5A);
        foreach (mk[i]) begin
            mw(1'b0, mk[i], 8'h96 ^ mk[i]);
            mw(1'b1, mk[i], 8'h69 ^ mk[i]);
        end
        rd(GMA_OFS_OUTPUT_LATCH, exp_out);
        port_in <= 16'h3CF0;
        rd(GMA_OFS_PIN_VALUE, 16'h0000);
        rd(GMA_OFS_PIN_VALUE, 16'h3CF0);
        rd(12'h7C0, 16'h00F0);
        rd(12'h830, 16'h0C00);
        rd(12'h400, 16'h0000);
        wr(GMA_OFS_PIN_VALUE, 16'h1234);
        rd(GMA_OFS_OUTPUT_LATCH, 16'h1234);
        wr(GMA_OFS_DIRECTION_SET, 16'h00F0);
        wr(GMA_OFS_DIRECTION_SET, 16'h0F00);
        wr(GMA_OFS_DIRECTION_SET, 16'h0000);
        rd(GMA_OFS_DIRECTION_SET, 16'h0FF0);
        wr(GMA_OFS_DIRECTION_CLEAR, 16'h0030);
        rd(GMA_OFS_DIRECTION_CLEAR, 16'h0FC0);
        wr(GMA_OFS_PIN_FUNCTION_SET, 16'h8001);
        wr(GMA_OFS_PIN_FUNCTION_SET, 16'h0000);
        rd(GMA_OFS_PIN_FUNCTION_SET, 16'h8001);
        wr(GMA_OFS_PIN_FUNCTION_CLEAR, 16'h0001);
        rd(GMA_OFS_PIN_FUNCTION_CLEAR, 16'h8000);
        wr(GMA_OFS_IRQ_ENABLE_SET, 16'h8001);
        wr(GMA_OFS_IRQ_ENABLE_SET, 16'h0000);
        rd(GMA_OFS_IRQ_ENABLE_SET, 16'h8001);
        @(negedge i_sys_clk);
        check("oe", {16'h0000, 16'h0FC0}, {16'h0000, port_oe});
        check("func", {16'h0000, 16'h8000}, {16'h0000, func_sel});
        check("irq", {16'h0000, 16'h8001}, {16'h0000, irq_en});
        check("hresp", 32'h0000_0000, 32'(hresp));
        check("hreadyout", 32'h0000_0001, 32'(hreadyout));
        wr(12'hC00, 16'hFFFF);
        rd(12'hC00, 16'h0000);
        rd(12'h008, 16'h0000);
        rd(GMA_OFS_OUTPUT_LATCH, 16'h1234);
        results();
    end

    // Watchdog: the tests need under 150 cycles
    initial begin
        #50000;
        n_errors++;
        results();
    end
endmodule
